// ==== sim/vom_axis_test.sv ====
// testbench of the output axis: bus, motion, flags, torque source.
// assumes the axis top beside a servo amplifier model.
`timescale 1ns/1ps
module vom_axis_test;
  import vom_pkg::*;
  logic i_clk, i_rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, dev, rd_v;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic signed [31:0] dspd, dtrv, rspd, rtrv, cspd, ctrv;
  logic dval, rval, clutch, cval, virt, flag, irq, stall;
  logic [15:0] tqw, tq, tqsrc, tpp;
  int mismatches, compares, cycles;
  vom_axis uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hF),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .i_drive_speed(dspd), .i_drive_travel(dtrv),
    .i_drive_valid(dval), .i_clutch_on(clutch), .i_real_speed(rspd),
    .i_real_travel(rtrv), .i_real_valid(rval), .i_deviation(dev),
    .i_torque_word(tqw), .o_cmd_speed(cspd), .o_cmd_travel(ctrv),
    .o_cmd_valid(cval), .o_torque_limit(tq), .o_torque_src(tqsrc),
    .o_travel_per_pulse(tpp), .o_virtual(virt),
    .o_axis_error_flag(flag), .o_irq(irq));
  vom_servo_model amp (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cmd_travel(ctrv), .i_cmd_valid(cval), .i_stall(stall),
    .o_deviation(dev));
  // free-running 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // closing report, also reached by the hang limit
  task summarize;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang limit, far above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // single comparison point
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // write: address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask
  // read: result lands in rd_v and rsp
  task rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = arvalid && arready;
      tr = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge i_clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
  endtask
  // one motion sample, drive side or real side, waits for the command
  task mv(input logic rm, input logic signed [31:0] s,
          input logic signed [31:0] t);
    dspd <= s;
    dtrv <= t;
    rspd <= s;
    rtrv <= t;
    dval <= !rm;
    rval <= rm;
    @(posedge i_clk);
    dval <= 1'b0;
    rval <= 1'b0;
    do @(negedge i_clk); while (!cval);
    @(posedge i_clk);
  endtask
  task automatic t_reset;
    logic [7:0] a[6] = '{OFS_DEV_LIM, OFS_ST_UP, OFS_ST_LO, OFS_GEAR,
                         OFS_TPP, OFS_SPD_LIM};
    logic [31:0] e[6] = '{RST_DEV_LIM, RST_ST_UP, RST_ST_LO, RST_GEAR,
                          32'(RST_TPP), 32'h0};
    chk(32'(tq), 32'(TQ_DEFAULT));
    chk(32'(tpp), 32'(RST_TPP));
    for (int i = 0; i < 6; i++) begin
      rd(a[i]);
      chk(rd_v, e[i]);
    end
    rd(8'h3C);
    chk({rd_v[29:0], rsp}, {30'h0, RESP_ERR});
    wr(8'h3C, 32'h1);
    chk(32'(rsp), 32'(RESP_ERR));
    $display("test reset done");
  endtask
  task t_mode;
    wr(OFS_CTRL, 32'h3); // inch output, mm fixed, ask virtual
    tick(2);
    rd(OFS_STS);
    chk(rd_v, 32'h8);
    chk(32'(virt), 32'h0);
    wr(OFS_STS, 32'h8);
    wr(OFS_CTRL, 32'h7); // units agree now
    tick(2);
    chk(32'(virt), 32'h1);
    rd(OFS_STS);
    chk(rd_v, 32'h0);
    $display("test mode done");
  endtask
  task t_gear;
    wr(OFS_BACKLASH, 32'h5);
    wr(OFS_GEAR, 32'h20000); // ratio 2.0
    clutch <= 1'b1;
    mv(1'b0, 32'h32, 32'h64); // first move, no backlash added
    chk(cspd, 32'h64);
    chk(ctrv, 32'hC8);
    clutch <= 1'b0;
    mv(1'b0, 32'h32, 32'h64);
    chk({cspd | ctrv}, 32'h0);
    wr(OFS_CTRL, 32'h6); // back to real mode
    rd(OFS_FEED);
    chk(rd_v, 32'hC8);
    mv(1'b1, 32'h7, 32'hFFFFFFF6); // reversal by 10 pulses
    chk(ctrv, 32'hFFFFFFF1);
    wr(OFS_CTRL, 32'h7);
    rd(OFS_FEED);
    chk(rd_v, 32'hBE);
    wr(OFS_BACKLASH, 32'h0);
    clutch <= 1'b1;
    $display("test gear done");
  endtask
  task t_dev;
    wr(OFS_DEV_LIM, 32'h96); // 150 pulses, inside the legal span
    stall <= 1'b1;
    mv(1'b0, 32'h0, 32'h64); // lag becomes 200
    tick(2);
    chk(32'({flag, irq}), 32'h2);
    mv(1'b0, 32'h0, 32'hA); // axis keeps running
    chk(ctrv, 32'h14);
    stall <= 1'b0;
    tick(3);
    chk(32'(flag), 32'h1);
    wr(OFS_MASK, 32'h1);
    tick(1);
    chk(32'(irq), 32'h1);
    wr(OFS_STS, 32'h1);
    tick(1);
    chk(32'({flag, irq}), 32'h0);
    wr(OFS_DEV_LIM, RST_DEV_LIM);
    $display("test deviation done");
  endtask
  task t_spd;
    wr(OFS_SPD_LIM, 32'h64); // 100 pls/s, inside the legal span
    mv(1'b0, 32'h28, 32'h0); // geared 80
    rd(OFS_STS);
    chk(rd_v, 32'h0);
    mv(1'b0, 32'h50, 32'h0); // geared 160
    chk(cspd, 32'hA0);
    rd(OFS_STS);
    chk(rd_v, 32'h4);
    wr(OFS_SPD_LIM, 32'h0);
    wr(OFS_STS, 32'h4);
    $display("test speed done");
  endtask
  task t_stroke;
    wr(OFS_ST_UP, 32'h1B8); // feed is 410, limit 440
    mv(1'b0, 32'h0, 32'hF); // lands exactly on the limit
    rd(OFS_STS);
    chk(rd_v, 32'h0);
    mv(1'b0, 32'h0, 32'h1);
    mv(1'b0, 32'h0, 32'h1); // no stop: motion still goes out
    chk(ctrv, 32'h2);
    rd(OFS_STS);
    chk(rd_v | 32'(flag), 32'h3);
    wr(OFS_ST_UP, RST_ST_UP);
    wr(OFS_STS, 32'h2);
    $display("test stroke done");
  endtask
  task automatic t_tq;
    // data, link, motion and shared sources, clear of data 800..1559
    logic [15:0] src[4] = '{16'h9FFF, 16'hBFFF, 16'hDF3F, 16'hE000};
    tqw <= 16'h1F4; // 500 percent, inside 1..1000
    for (int i = 0; i < 4; i++) begin
      wr(OFS_TQ_SRC, 32'(src[i]));
      tick(2);
      chk(32'(tqsrc), 32'(src[i]));
      chk(32'(tq), 32'h1F4);
    end
    wr(OFS_TQ_SRC, 32'hDF40); // motion index 8000
    tick(2);
    chk(32'(tq), 32'h12C);
    rd(OFS_STS);
    chk(rd_v, 32'h10);
    wr(OFS_TQ_SRC, 32'h0); // no source configured
    tick(2);
    chk(32'(tq), 32'h12C);
    $display("test torque done");
  endtask
  // main sequence
  initial begin
    // bready and rready stay high: every answer is taken at once
    {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
    {dval, rval, clutch, stall} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {dspd, dtrv, rspd, rtrv} = 128'h0;
    tqw = 16'h0064;
    i_rst_b = 1'b0;
    tick(10);
    i_rst_b <= 1'b1;
    t_reset();
    t_mode();
    t_gear();
    t_dev();
    t_spd();
    t_stroke();
    t_tq();
    summarize();
  end
endmodule

// ==== sim/vom_servo_model.sv ====
// servo amplifier model: takes the axis command and reports its lag.
// assumes the command strobe is one cycle wide per sample.
`timescale 1ns/1ps
module vom_servo_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic signed [31:0] i_cmd_travel,
  input wire logic i_cmd_valid,
  input wire logic i_stall,
  output logic [31:0] o_deviation
);
  // a stalled motor lets every command pile up as lag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_deviation <= 32'h00000000;
    end else if (!i_stall) begin
      o_deviation <= 32'h00000000; // motor has caught up
    end else if (i_cmd_valid) begin
      o_deviation <= o_deviation +
        32'(i_cmd_travel < 0 ? -i_cmd_travel : i_cmd_travel);
    end
  end
endmodule

// ==== src/vom_axis.sv ====
// ball-screw output axis of a virtual-mode motion controller.
// assumes an axi4-lite master, a servo amplifier taking the command
// strobe, and user logic fetching the torque source word.
// Operation
// - unit mismatch on entering virtual mode errors
// - deviation over threshold sets flag, keeps running
// - stroke limits default upper max, lower zero
// - outside stroke sets flag, no stop
// - over speed limit sets flag, no clamp
// - torque limit from source, else 300 percent
// - source kinds data, link, motion, shared
// - command equals drive motion times gear ratio
// - follow drive only while clutch engaged
// - feed value carries over mode switches
// - backlash compensation continues across mode switches
// - travel per pulse from fixed parameter only
`timescale 1ns/1ps
module vom_axis
  import vom_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic signed [31:0] i_drive_speed,
  input wire logic signed [31:0] i_drive_travel,
  input wire logic i_drive_valid,
  input wire logic i_clutch_on,
  input wire logic signed [31:0] i_real_speed,
  input wire logic signed [31:0] i_real_travel,
  input wire logic i_real_valid,
  input wire logic [31:0] i_deviation,
  input wire logic [15:0] i_torque_word,
  output logic signed [31:0] o_cmd_speed,
  output logic signed [31:0] o_cmd_travel,
  output logic o_cmd_valid,
  output logic [15:0] o_torque_limit,
  output logic [15:0] o_torque_src,
  output logic [15:0] o_travel_per_pulse,
  output logic o_virtual,
  output logic o_axis_error_flag,
  output logic o_irq
);
  typedef struct packed {
    logic aw_ok; // write address held
    logic w_ok; // write data held
    logic [7:0] awaddr; // held write address
    logic [31:0] wdata; // held write data
    logic [3:0] wstrb; // held byte enables
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [1:0] rresp; // read response code
    logic [31:0] rdata; // read data
    logic [2:0] ctrl; // control bits
    logic [31:0] dev_lim; // deviation threshold
    logic [31:0] st_up; // upper stroke, 0.1 um
    logic [31:0] st_lo; // lower stroke, 0.1 um
    logic [31:0] spd_lim; // speed limit, pls/s, 0 = none
    logic [31:0] gear; // gear ratio
    logic [15:0] tq_src; // torque source setting
    logic [NSTS-1:0] sts; // sticky events
    logic [NSTS-1:0] mask; // interrupt mask
    logic [15:0] backlash; // backlash amount
    logic [15:0] tpp; // fixed travel per pulse
    vom_mode_t mode; // active mode
    logic signed [31:0] feed; // feed current value
    logic dir_known; // a direction has been seen
    logic last_neg; // last direction was negative
    logic signed [31:0] out_spd; // command speed
    logic signed [31:0] out_trv; // command travel
    logic out_vld; // command strobe
    logic [15:0] tq; // applied torque limit
  } vom_axis_st_t;
  vom_axis_st_t s; // registered state
  vom_axis_st_t next_s; // next state
  vom_gear_if gif(); // gear stage carrier
  logic [NSTS-1:0] ev; // events this cycle
  logic [NSTS-1:0] sts_clr; // bits cleared by software
  logic signed [31:0] src_spd; // selected motion source
  logic signed [31:0] src_trv;
  logic src_vld;
  logic signed [31:0] comp; // backlash correction
  logic signed [47:0] pos; // feed in stroke units
  logic [31:0] spd_abs; // command speed magnitude
  logic tq_ok; // torque source usable
  logic wr_fire; // register write this cycle

  // merge bytes of a write under its byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // torque source index inside the range of its kind
  function automatic logic tq_idx_ok(input logic [15:0] src);
    logic [12:0] idx;
    idx = src[TQ_IDX_MSB:0];
    case (src[TQ_KIND_LSB +: 2])
      TQ_DATA: tq_idx_ok = (idx <= DATA_IDX_MAX);
      TQ_LINK: tq_idx_ok = (idx <= LINK_IDX_MAX);
      TQ_MOTION: tq_idx_ok = (idx <= MOTION_IDX_MAX);
      default: tq_idx_ok = 1'b1; // shared area word
    endcase
  endfunction

  vom_gear u_gear (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .g(gif)
  );
  assign gif.spd = i_drive_speed;
  assign gif.trv = i_drive_travel;
  assign gif.in_valid = i_drive_valid;
  assign gif.clutch = i_clutch_on;
  assign gif.ratio = s.gear;

  // bus handshakes, one write and one read at a time
  assign o_axi_awready = !s.aw_ok;
  assign o_axi_wready = !s.w_ok;
  assign o_axi_arready = !s.rvalid;

  // next-state logic for bus, registers, mode and motion
  always_comb begin
    next_s = s;
    sts_clr = '0;
    ev = '0;
    wr_fire = s.aw_ok && s.w_ok && !s.bvalid;
    if (i_axi_awvalid && !s.aw_ok) begin // take write address
      next_s.aw_ok = 1'b1;
      next_s.awaddr = i_axi_awaddr;
    end
    if (i_axi_wvalid && !s.w_ok) begin // take write data
      next_s.w_ok = 1'b1;
      next_s.wdata = i_axi_wdata;
      next_s.wstrb = i_axi_wstrb;
    end
    if (s.bvalid && i_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin // apply write once both halves held
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OK;
      case (s.awaddr)
        OFS_CTRL:
          next_s.ctrl = 3'(wmerge({29'h0, s.ctrl}, s.wdata, s.wstrb));
        OFS_DEV_LIM: next_s.dev_lim = wmerge(s.dev_lim, s.wdata, s.wstrb);
        OFS_ST_UP: next_s.st_up = wmerge(s.st_up, s.wdata, s.wstrb);
        OFS_ST_LO: next_s.st_lo = wmerge(s.st_lo, s.wdata, s.wstrb);
        OFS_SPD_LIM: next_s.spd_lim = wmerge(s.spd_lim, s.wdata, s.wstrb);
        OFS_GEAR: next_s.gear = wmerge(s.gear, s.wdata, s.wstrb);
        OFS_TQ_SRC:
          next_s.tq_src = 16'(wmerge({16'h0, s.tq_src}, s.wdata,
                                     s.wstrb));
        OFS_STS: sts_clr = s.wstrb[0] ? s.wdata[NSTS-1:0] : '0;
        OFS_MASK:
          next_s.mask = NSTS'(wmerge({27'h0, s.mask}, s.wdata,
                                     s.wstrb));
        OFS_BACKLASH:
          next_s.backlash = 16'(wmerge({16'h0, s.backlash}, s.wdata,
                                       s.wstrb));
        OFS_TPP: // fixed parameter, only source of travel per pulse
          next_s.tpp = 16'(wmerge({16'h0, s.tpp}, s.wdata,
                                  s.wstrb));
        OFS_FEED, OFS_MODE: next_s.bresp = RESP_OK; // read only
        default: next_s.bresp = RESP_ERR; // unmapped
      endcase
    end
    if (s.rvalid && i_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (i_axi_arvalid && !s.rvalid) begin // answer a read
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OK;
      case (i_axi_araddr)
        OFS_CTRL: next_s.rdata = {29'h0, s.ctrl};
        OFS_DEV_LIM: next_s.rdata = s.dev_lim;
        OFS_ST_UP: next_s.rdata = s.st_up;
        OFS_ST_LO: next_s.rdata = s.st_lo;
        OFS_SPD_LIM: next_s.rdata = s.spd_lim;
        OFS_GEAR: next_s.rdata = s.gear;
        OFS_TQ_SRC: next_s.rdata = {16'h0, s.tq_src};
        OFS_STS: next_s.rdata = {27'h0, s.sts};
        OFS_MASK: next_s.rdata = {27'h0, s.mask};
        OFS_FEED: next_s.rdata = s.feed;
        OFS_MODE: next_s.rdata = {31'h0, s.mode};
        OFS_BACKLASH: next_s.rdata = {16'h0, s.backlash};
        OFS_TPP: next_s.rdata = {16'h0, s.tpp};
        default: begin // unmapped
          next_s.rdata = 32'h00000000;
          next_s.rresp = RESP_ERR;
        end
      endcase
    end
    // mode switching
    case (s.mode)
      MODE_REAL: begin
        if (s.ctrl[CTRL_VIRT]) begin
          if (s.ctrl[CTRL_UNIT] != s.ctrl[CTRL_FIX_UNIT]) begin
            ev[ST_MODE] = 1'b1;
            next_s.ctrl[CTRL_VIRT] = 1'b0; // request refused
          end else begin
            next_s.mode = MODE_VIRT;
          end
        end
      end
      MODE_VIRT: begin
        if (!s.ctrl[CTRL_VIRT]) begin
          next_s.mode = MODE_REAL;
        end
      end
      default: next_s.mode = MODE_REAL;
    endcase
    // motion source: geared drive in virtual mode
    if (s.mode == MODE_VIRT) begin
      src_spd = gif.out_spd;
      src_trv = gif.out_trv;
      src_vld = gif.out_valid;
    end else begin
      src_spd = i_real_speed;
      src_trv = i_real_travel;
      src_vld = i_real_valid;
    end
    // backlash added on reversal in either mode
    comp = 32'sh00000000;
    if (src_trv != 32'sh00000000 && s.dir_known &&
        src_trv[31] != s.last_neg) begin
      comp = src_trv[31] ? -$signed({16'h0, s.backlash})
                         : $signed({16'h0, s.backlash});
    end
    next_s.out_vld = src_vld;
    if (src_vld) begin
      next_s.out_spd = src_spd; // never clamped
      next_s.out_trv = src_trv + comp;
      next_s.feed = s.feed + src_trv; // kept across modes
      if (src_trv != 32'sh00000000) begin
        next_s.dir_known = 1'b1;
        next_s.last_neg = src_trv[31];
      end
    end
    // limit checks, virtual mode only; no stop is issued
    pos = 48'(s.feed) * 48'($signed({1'b0, s.tpp}));
    spd_abs = s.out_spd[31] ? 32'(-s.out_spd) : 32'(s.out_spd);
    if (s.mode == MODE_VIRT) begin
      ev[ST_DEV] = (i_deviation > s.dev_lim);
      ev[ST_STROKE] = (pos > 48'($signed(s.st_up))) ||
                      (pos < 48'($signed(s.st_lo)));
      ev[ST_SPEED] = s.out_vld && (s.spd_lim != 32'h00000000) &&
                     (spd_abs > s.spd_lim);
    end
    // torque source: word when configured with an index in range, else default
    tq_ok = s.tq_src[TQ_CFG] && tq_idx_ok(s.tq_src);
    ev[ST_TQSRC] = s.tq_src[TQ_CFG] && !tq_idx_ok(s.tq_src);
    next_s.tq = tq_ok ? i_torque_word : TQ_DEFAULT;
    // events win over a clear in the same cycle
    next_s.sts = (s.sts & ~sts_clr) | ev;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.dev_lim <= RST_DEV_LIM;
      s.st_up <= RST_ST_UP;
      s.st_lo <= RST_ST_LO;
      s.gear <= RST_GEAR;
      s.tpp <= RST_TPP;
      s.tq <= TQ_DEFAULT;
      s.mode <= MODE_REAL;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign o_axi_bvalid = s.bvalid;
  assign o_axi_bresp = s.bresp;
  assign o_axi_rvalid = s.rvalid;
  assign o_axi_rresp = s.rresp;
  assign o_axi_rdata = s.rdata;
  assign o_cmd_speed = s.out_spd;
  assign o_cmd_travel = s.out_trv;
  assign o_cmd_valid = s.out_vld;
  assign o_torque_limit = s.tq;
  assign o_torque_src = s.tq_src;
  assign o_travel_per_pulse = s.tpp;
  assign o_virtual = (s.mode == MODE_VIRT);
  assign o_axis_error_flag = |s.sts[ST_SPEED:ST_DEV];
  assign o_irq = |(s.sts & s.mask);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  dev_flag_a: assert property (
    (s.mode == MODE_VIRT && s.ctrl[CTRL_VIRT] &&
     i_deviation > s.dev_lim) |=>
      s.sts[ST_DEV] && s.mode == MODE_VIRT)
    else $error("deviation flag not set");
  flag_hold_a: assert property (
    (s.sts[ST_DEV] && !sts_clr[ST_DEV]) |=> s.sts[ST_DEV])
    else $error("error flag dropped without clear");
  stroke_flag_a: assert property (
    (ev[ST_STROKE] && s.ctrl[CTRL_VIRT]) |=>
      s.sts[ST_STROKE] && s.mode == MODE_VIRT)
    else $error("stroke flag missing or axis stopped");
  speed_flag_a: assert property (
    ev[ST_SPEED] |=> s.sts[ST_SPEED] && o_axis_error_flag)
    else $error("speed flag not set");
  torque_default_a: assert property (
    !s.tq_src[TQ_CFG] ##1 !s.tq_src[TQ_CFG] |->
      o_torque_limit == TQ_DEFAULT)
    else $error("torque default not applied");
  torque_index_a: assert property (
    (s.tq_src[TQ_CFG] && s.tq_src[TQ_KIND_LSB +: 2] == TQ_MOTION &&
     s.tq_src[TQ_IDX_MSB:0] > MOTION_IDX_MAX) |=>
      s.sts[ST_TQSRC] && o_torque_limit == TQ_DEFAULT)
    else $error("bad torque source accepted");
  mode_error_a: assert property (
    (s.mode == MODE_REAL && s.ctrl[CTRL_VIRT] &&
     s.ctrl[CTRL_UNIT] != s.ctrl[CTRL_FIX_UNIT]) |=>
      s.sts[ST_MODE] && s.mode == MODE_REAL)
    else $error("unit mismatch not refused");
  feed_keep_a: assert property (
    ($changed(s.mode) && !$past(src_vld)) |-> s.feed == $past(s.feed))
    else $error("feed value lost on mode switch");
  clutch_open_a: assert property (
    (gif.in_valid && !gif.clutch) |=> gif.out_trv == 32'sh00000000)
    else $error("motion passed with clutch open");
  gear_out_a: assert property (
    (s.mode == MODE_VIRT && gif.out_valid &&
     !s.dir_known) ##1 s.mode == MODE_VIRT |->
      o_cmd_valid && o_cmd_travel == $past(gif.out_trv))
    else $error("geared motion not commanded");
endmodule

// ==== src/vom_gear.sv ====
// gear stage: scales drive motion by the transmission ratio.
// assumes the drive sample is steady while in_valid is high.
`timescale 1ns/1ps
module vom_gear
  import vom_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  vom_gear_if.gear g
);
  typedef struct packed {
    logic signed [31:0] spd; // geared speed
    logic signed [31:0] trv; // geared travel
    logic vld; // result strobe
  } vom_gear_st_t;
  vom_gear_st_t st; // registered state
  vom_gear_st_t next_st; // next state
  logic signed [64:0] p_spd; // full speed product
  logic signed [64:0] p_trv; // full travel product

  // multiply and drop the 16 fraction bits
  always_comb begin
    next_st = st;
    p_spd = 65'(g.spd) * 65'($signed({1'b0, g.ratio}));
    p_trv = 65'(g.trv) * 65'($signed({1'b0, g.ratio}));
    next_st.vld = g.in_valid;
    if (g.clutch) begin // motion follows drive
      next_st.spd = p_spd[47:16];
      next_st.trv = p_trv[47:16];
    end else begin // clutch open: output stands still
      next_st.spd = 32'sh00000000;
      next_st.trv = 32'sh00000000;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign g.out_spd = st.spd;
  assign g.out_trv = st.trv;
  assign g.out_valid = st.vld;
endmodule

// ==== src/vom_gear_if.sv ====
// carrier between the axis top and its gear stage.
// assumes both ends share one clock.
`timescale 1ns/1ps
interface vom_gear_if;
  logic signed [31:0] spd; // drive module speed, pls/s
  logic signed [31:0] trv; // drive module travel, pls
  logic in_valid; // drive sample strobe
  logic clutch; // clutch engaged
  logic [31:0] ratio; // gear ratio q16.16
  logic signed [31:0] out_spd; // geared speed
  logic signed [31:0] out_trv; // geared travel
  logic out_valid; // geared sample strobe
  modport gear(input spd, trv, in_valid, clutch, ratio,
               output out_spd, out_trv, out_valid);
  modport axis(output spd, trv, in_valid, clutch, ratio,
               input out_spd, out_trv, out_valid);
endinterface

// ==== src/vom_pkg.sv ====
// package of the virtual output axis: register map, field positions,
// reset values and mode encoding.
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
package vom_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // mode request and units
  localparam logic [7:0] OFS_DEV_LIM = 8'h08; // permissible deviation
  localparam logic [7:0] OFS_ST_UP = 8'h0C; // upper stroke limit
  localparam logic [7:0] OFS_ST_LO = 8'h10; // lower stroke limit
  localparam logic [7:0] OFS_SPD_LIM = 8'h14; // speed limit in pls/s
  localparam logic [7:0] OFS_GEAR = 8'h18; // gear ratio, q16.16
  localparam logic [7:0] OFS_TQ_SRC = 8'h1C; // torque source word
  localparam logic [7:0] OFS_STS = 8'h24; // sticky events, w1c
  localparam logic [7:0] OFS_MASK = 8'h28; // interrupt mask
  localparam logic [7:0] OFS_FEED = 8'h2C; // feed current value, ro
  localparam logic [7:0] OFS_MODE = 8'h30; // active mode, ro
  localparam logic [7:0] OFS_BACKLASH = 8'h34; // backlash in pulses
  localparam logic [7:0] OFS_TPP = 8'h38; // fixed travel per pulse
  // control bit positions
  localparam int CTRL_VIRT = 0; // request virtual mode
  localparam int CTRL_UNIT = 1; // output unit: 1 = inch
  localparam int CTRL_FIX_UNIT = 2; // fixed-parameter unit: 1 = inch
  // torque source field positions
  localparam int TQ_IDX_MSB = 12; // word index, bits 12..0
  localparam int TQ_KIND_LSB = 13; // kind, bits 14..13
  localparam int TQ_CFG = 15; // a source is configured
  localparam logic [1:0] TQ_DATA = 2'h0; // data register
  localparam logic [1:0] TQ_LINK = 2'h1; // link register
  localparam logic [1:0] TQ_MOTION = 2'h2; // motion register
  localparam logic [1:0] TQ_SHARED = 2'h3; // multi-cpu area word
  localparam logic [12:0] DATA_IDX_MAX = 13'h1FFF; // 8191
  localparam logic [12:0] LINK_IDX_MAX = 13'h1FFF;
  localparam logic [12:0] MOTION_IDX_MAX = 13'h1F3F; // 7999
  // status bit positions
  localparam int ST_DEV = 0; // deviation over threshold
  localparam int ST_STROKE = 1; // position outside stroke
  localparam int ST_SPEED = 2; // speed over limit
  localparam int ST_MODE = 3; // mode switching error
  localparam int ST_TQSRC = 4; // torque source index out of range
  localparam int NSTS = 5;
  // reset values
  localparam logic [31:0] RST_DEV_LIM = 32'h0063FF9C; // 6553500
  localparam logic [31:0] RST_ST_UP = 32'h7FFFFFFF; // 214748364.7 um
  localparam logic [31:0] RST_ST_LO = 32'h00000000;
  localparam logic [31:0] RST_GEAR = 32'h00010000; // ratio 1.0
  localparam logic [15:0] RST_TPP = 16'h0001;
  localparam logic [15:0] TQ_DEFAULT = 16'h012C; // 300 percent
  // bus responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [0:0] {
    MODE_REAL = 1'b0,
    MODE_VIRT = 1'b1
  } vom_mode_t;
endpackage
